// >>> src/ext_bus_adapter.sv
// external bus width and endian adapter: splits internal accesses over 8/16/32-bit banks
// assumes the bank pointers and widths are held stable by the system configuration logic
`timescale 1ns/1ps
module ext_bus_adapter (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic little_endian,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [1:0] req_size,
  input wire logic [ext_bus_pkg::ADDR_W-1:0] req_addr,
  input wire logic [31:0] req_wdata,
  output logic rsp_valid,
  output logic rsp_error,
  output logic [31:0] rsp_rdata,
  input wire logic [ext_bus_pkg::ROM_BANKS-1:0][ext_bus_pkg::PTR_W-1:0] rom_base_ptr,
  input wire logic [ext_bus_pkg::ROM_BANKS-1:0][ext_bus_pkg::PTR_W-1:0] rom_next_ptr,
  input wire logic [ext_bus_pkg::ROM_BANKS-1:0][1:0] rom_width,
  input wire logic [ext_bus_pkg::DRAM_BANKS-1:0][ext_bus_pkg::PTR_W-1:0] dram_base_ptr,
  input wire logic [ext_bus_pkg::DRAM_BANKS-1:0][ext_bus_pkg::PTR_W-1:0] dram_next_ptr,
  input wire logic [ext_bus_pkg::DRAM_BANKS-1:0][1:0] dram_width,
  input wire logic [ext_bus_pkg::PTR_W-1:0] io_base_ptr,
  input wire logic [ext_bus_pkg::IO_BANKS-1:0][1:0] io_width,
  output logic [ext_bus_pkg::EXT_ADDR_W-1:0] ext_addr,
  output logic [31:0] external_data_bus_o,
  input wire logic [31:0] external_data_bus_i,
  output logic external_data_bus_oe,
  input wire logic ext_ready,
  output logic read_strobe_n,
  output logic [ext_bus_pkg::DRAM_BANKS-1:0] row_strobe_n,
  output logic [3:0] column_strobe_n,
  output logic [ext_bus_pkg::IO_BANKS-1:0] io_bank_select_n,
  output logic [ext_bus_pkg::ROM_BANKS-1:0] rom_bank_select_n,
  output logic [3:0] byte_write_strobe_n
);
  // ************************************************************
  // lane mapping: {valid, byte significance} for one lane of one piece
  // ************************************************************
  function automatic logic [2:0] lane_sig(input logic [1:0] start, input logic [1:0] size,
                                          input logic [1:0] lw, input logic little,
                                          input logic [1:0] k, input int lane);
    int wb;
    int nb;
    int pos;
    int j;
    wb = 1 << lw;
    nb = 1 << size;
    pos = little ? lane : wb - 1 - lane;
    j = (int'(start) / wb) * wb - int'(start) + int'(k) * wb + pos;
    if (lane >= wb || j < 0 || j >= nb) return 3'h0;
    return {1'b1, little ? 2'(j) : 2'(nb - 1 - j)};
  endfunction : lane_sig

  // ************************************************************
  // request and piece state
  // ************************************************************
  ext_bus_pkg::seq_state_t state_ff, nxt_state;
  logic [1:0] k_ff, nxt_k, last_ff, nxt_last, size_ff, nxt_size, lw_ff, nxt_lw;
  logic write_ff, nxt_write, little_ff, nxt_little, err_ff, nxt_err;
  logic [ext_bus_pkg::ADDR_W-1:0] ofs_ff, nxt_ofs;
  logic [31:0] wdata_ff, nxt_wdata, asm_ff, nxt_asm, rdata_ff, nxt_rdata;
  logic [ext_bus_pkg::ROM_BANKS-1:0] rom_sel_ff, nxt_rom_sel;
  logic [ext_bus_pkg::IO_BANKS-1:0] io_sel_ff, nxt_io_sel;
  logic [ext_bus_pkg::DRAM_BANKS-1:0] dram_sel_ff, nxt_dram_sel;
  logic [3:0] lane_ff, nxt_lane;
  logic [31:0] xd_ff, nxt_xd;
  logic [ext_bus_pkg::EXT_ADDR_W-1:0] eaddr_ff, nxt_eaddr;
  logic active_ff, nxt_active;

  // ************************************************************
  // bank decode by pointer subtraction
  // ************************************************************
  logic [ext_bus_pkg::PTR_W-1:0] addr_hi;
  logic hit;
  logic [1:0] hit_w;
  logic [ext_bus_pkg::ADDR_W-1:0] hit_ofs;
  logic [ext_bus_pkg::ROM_BANKS-1:0] hit_rom;
  logic [ext_bus_pkg::IO_BANKS-1:0] hit_io;
  logic [ext_bus_pkg::DRAM_BANKS-1:0] hit_dram;

  assign addr_hi = req_addr[ext_bus_pkg::ADDR_W-1:ext_bus_pkg::PTR_LSB];

  always_comb begin
    logic [ext_bus_pkg::PTR_W:0] d_lo;
    logic [ext_bus_pkg::PTR_W:0] d_hi;
    logic [ext_bus_pkg::IO_SUB_W-1:0] sub;
    d_lo = '0;
    d_hi = '0;
    hit = 1'b0;
    hit_w = ext_bus_pkg::WIDTH_32;
    hit_ofs = '0;
    hit_rom = '0;
    hit_io = '0;
    hit_dram = '0;
    sub = req_addr[ext_bus_pkg::IO_SUB_LSB +: ext_bus_pkg::IO_SUB_W];
    for (int i = ext_bus_pkg::IO_BANKS - 1; i >= 0; i--) begin
      if (i == 0) begin
        d_lo = {1'b0, addr_hi} - {1'b0, io_base_ptr};
        if (d_lo == '0) begin
          hit = 1'b1;
          hit_io[sub] = 1'b1;
          hit_w = io_width[sub];
          hit_ofs = {{(ext_bus_pkg::ADDR_W-ext_bus_pkg::IO_SUB_LSB){1'b0}},
                     req_addr[ext_bus_pkg::IO_SUB_LSB-1:0]};
        end
      end
    end
    for (int i = ext_bus_pkg::DRAM_BANKS - 1; i >= 0; i--) begin
      d_lo = {1'b0, addr_hi} - {1'b0, dram_base_ptr[i]};
      d_hi = {1'b0, addr_hi} - {1'b0, dram_next_ptr[i]};
      if (!d_lo[ext_bus_pkg::PTR_W] && d_hi[ext_bus_pkg::PTR_W]) begin
        hit = 1'b1;
        hit_io = '0;
        hit_dram = '0;
        hit_dram[i] = 1'b1;
        hit_w = dram_width[i];
        hit_ofs = {d_lo[ext_bus_pkg::PTR_W-1:0], req_addr[ext_bus_pkg::PTR_LSB-1:0]};
      end
    end
    for (int i = ext_bus_pkg::ROM_BANKS - 1; i >= 0; i--) begin
      d_lo = {1'b0, addr_hi} - {1'b0, rom_base_ptr[i]};
      d_hi = {1'b0, addr_hi} - {1'b0, rom_next_ptr[i]};
      if (!d_lo[ext_bus_pkg::PTR_W] && d_hi[ext_bus_pkg::PTR_W]) begin
        hit = 1'b1;
        hit_io = '0;
        hit_dram = '0;
        hit_rom = '0;
        hit_rom[i] = 1'b1;
        hit_w = rom_width[i];
        hit_ofs = {d_lo[ext_bus_pkg::PTR_W-1:0], req_addr[ext_bus_pkg::PTR_LSB-1:0]};
      end
    end
    if (hit_w > ext_bus_pkg::WIDTH_32) hit_w = ext_bus_pkg::WIDTH_32;
  end

  // ************************************************************
  // sequencer next state
  // ************************************************************
  assign req_ready = (state_ff == ext_bus_pkg::ST_IDLE);

  always_comb begin
    logic [31:0] pbyte;
    logic [2:0] ls;
    nxt_state = state_ff;
    nxt_k = k_ff;
    nxt_last = last_ff;
    nxt_size = size_ff;
    nxt_lw = lw_ff;
    nxt_write = write_ff;
    nxt_little = little_ff;
    nxt_err = err_ff;
    nxt_ofs = ofs_ff;
    nxt_wdata = wdata_ff;
    nxt_asm = asm_ff;
    nxt_rdata = rdata_ff;
    nxt_rom_sel = rom_sel_ff;
    nxt_io_sel = io_sel_ff;
    nxt_dram_sel = dram_sel_ff;
    pbyte = '0;
    ls = '0;
    unique case (state_ff)
      ext_bus_pkg::ST_IDLE: begin
        if (req_valid) begin
          nxt_k = 2'h0;
          nxt_size = req_size;
          nxt_lw = hit_w;
          nxt_last = (req_size > hit_w) ? 2'((1 << (req_size - hit_w)) - 1) : 2'h0;
          nxt_write = req_write;
          nxt_little = little_endian;
          nxt_ofs = hit_ofs;
          nxt_wdata = req_wdata;
          nxt_asm = '0;
          nxt_rom_sel = hit_rom;
          nxt_io_sel = hit_io;
          nxt_dram_sel = hit_dram;
          nxt_err = !hit;
          nxt_state = hit ? ext_bus_pkg::ST_ACCESS : ext_bus_pkg::ST_FINISH;
        end
      end
      ext_bus_pkg::ST_ACCESS: begin
        if (ext_ready) begin
          for (int l = 0; l < ext_bus_pkg::LANES; l++) begin
            ls = lane_sig(ofs_ff[1:0], size_ff, lw_ff, little_ff, k_ff, l);
            if (ls[2] && !write_ff) begin
              nxt_asm[ls[1:0]*ext_bus_pkg::BYTE_W +: ext_bus_pkg::BYTE_W] =
                external_data_bus_i[l*ext_bus_pkg::BYTE_W +: ext_bus_pkg::BYTE_W];
            end
          end
          if (k_ff == last_ff) begin
            nxt_state = ext_bus_pkg::ST_FINISH;
            unique case (size_ff)
              ext_bus_pkg::SIZE_BYTE: nxt_rdata = {4{nxt_asm[7:0]}};
              ext_bus_pkg::SIZE_HALF: nxt_rdata = {2{nxt_asm[15:0]}};
              default: nxt_rdata = nxt_asm;
            endcase
          end else begin
            nxt_k = k_ff + 2'h1;
          end
        end
      end
      ext_bus_pkg::ST_FINISH: begin
        nxt_state = ext_bus_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = ext_bus_pkg::ST_IDLE;
      end
    endcase
    // piece outputs for the next cycle
    nxt_active = (nxt_state == ext_bus_pkg::ST_ACCESS);
    nxt_lane = '0;
    nxt_xd = '0;
    for (int l = 0; l < ext_bus_pkg::LANES; l++) begin
      ls = lane_sig(nxt_ofs[1:0], nxt_size, nxt_lw, nxt_little, nxt_k, l);
      if (ls[2] && nxt_active) begin
        nxt_lane[l] = 1'b1;
        nxt_xd[l*ext_bus_pkg::BYTE_W +: ext_bus_pkg::BYTE_W] =
          nxt_wdata[ls[1:0]*ext_bus_pkg::BYTE_W +: ext_bus_pkg::BYTE_W];
      end
    end
    if (nxt_active && nxt_size == ext_bus_pkg::SIZE_HALF && nxt_lw == ext_bus_pkg::WIDTH_32)
      nxt_xd = {2{nxt_wdata[15:0]}};
    pbyte = 32'((nxt_ofs >> nxt_lw) + {30'h0, nxt_k});
    nxt_eaddr = nxt_active ? pbyte[ext_bus_pkg::EXT_ADDR_W-1:0] : eaddr_ff;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ext_bus_pkg::ST_IDLE;
      k_ff <= '0;
      last_ff <= '0;
      size_ff <= '0;
      lw_ff <= '0;
      write_ff <= 1'b0;
      little_ff <= 1'b0;
      err_ff <= 1'b0;
      ofs_ff <= '0;
      wdata_ff <= '0;
      asm_ff <= '0;
      rdata_ff <= '0;
      rom_sel_ff <= '0;
      io_sel_ff <= '0;
      dram_sel_ff <= '0;
      lane_ff <= '0;
      xd_ff <= '0;
      eaddr_ff <= '0;
      active_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      k_ff <= nxt_k;
      last_ff <= nxt_last;
      size_ff <= nxt_size;
      lw_ff <= nxt_lw;
      write_ff <= nxt_write;
      little_ff <= nxt_little;
      err_ff <= nxt_err;
      ofs_ff <= nxt_ofs;
      wdata_ff <= nxt_wdata;
      asm_ff <= nxt_asm;
      rdata_ff <= nxt_rdata;
      rom_sel_ff <= nxt_rom_sel;
      io_sel_ff <= nxt_io_sel;
      dram_sel_ff <= nxt_dram_sel;
      lane_ff <= nxt_lane;
      xd_ff <= nxt_xd;
      eaddr_ff <= nxt_eaddr;
      active_ff <= nxt_active;
    end
  end

  // ************************************************************
  // pin drive
  // ************************************************************
  logic dram_acc;
  assign dram_acc = |dram_sel_ff;
  assign rsp_valid = (state_ff == ext_bus_pkg::ST_FINISH);
  assign rsp_error = rsp_valid && err_ff;
  assign rsp_rdata = rdata_ff;
  assign ext_addr = eaddr_ff;
  assign external_data_bus_o = xd_ff;
  assign external_data_bus_oe = active_ff && write_ff;
  assign read_strobe_n = !(active_ff && !write_ff);
  assign row_strobe_n = ~(dram_sel_ff & {ext_bus_pkg::DRAM_BANKS{active_ff}});
  assign column_strobe_n = (active_ff && dram_acc) ? ~lane_ff : 4'hF;
  assign byte_write_strobe_n = (active_ff && write_ff && !dram_acc) ? ~lane_ff : 4'hF;
  assign io_bank_select_n = ~(io_sel_ff & {ext_bus_pkg::IO_BANKS{active_ff}});
  assign rom_bank_select_n = ~(rom_sel_ff & {ext_bus_pkg::ROM_BANKS{active_ff}});

  // ************************************************************
  // checks
  // ************************************************************
  stall_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    active_ff |-> !req_ready && !rsp_valid) else $error("master not stalled during access");
  one_bank_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    active_ff |-> $onehot({rom_sel_ff, io_sel_ff, dram_sel_ff})) else $error("bank select not one-hot");
  addr_shift_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    active_ff && k_ff == 2'h0 && lw_ff == ext_bus_pkg::WIDTH_32 |-> ext_addr == ofs_ff[23:2])
    else $error("32-bit bank address not offset bits 23..2");
  half_split_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    active_ff && write_ff && !little_ff && lw_ff == ext_bus_pkg::WIDTH_16 && size_ff == ext_bus_pkg::SIZE_WORD
    && k_ff == 2'h1 |-> ext_addr == ofs_ff[22:1] + 22'h1 && byte_write_strobe_n[1:0] == 2'h0
    && external_data_bus_o[15:0] == wdata_ff[15:0]) else $error("second half write wrong");
  byte_msb_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    active_ff && !little_ff && lw_ff == ext_bus_pkg::WIDTH_8 && size_ff == ext_bus_pkg::SIZE_WORD
    && k_ff == 2'h0 && write_ff |-> external_data_bus_o[7:0] == wdata_ff[31:24] && lane_ff == 4'h1)
    else $error("first byte piece not msb");
  half_repl_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    active_ff && write_ff && !little_ff && lw_ff == ext_bus_pkg::WIDTH_32 && size_ff == ext_bus_pkg::SIZE_HALF
    && !dram_acc |-> byte_write_strobe_n == (ofs_ff[1] ? 4'hC : 4'h3)
    && external_data_bus_o == {2{wdata_ff[15:0]}}) else $error("half strobe or data pattern");
  little_lane_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    active_ff && little_ff && lw_ff == ext_bus_pkg::WIDTH_32 && size_ff == ext_bus_pkg::SIZE_BYTE
    |-> lane_ff == 4'(1 << ofs_ff[1:0])) else $error("little endian lane wrong");
  big_lane_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    active_ff && !little_ff && lw_ff == ext_bus_pkg::WIDTH_32 && size_ff == ext_bus_pkg::SIZE_BYTE
    |-> lane_ff == 4'(4'h8 >> ofs_ff[1:0])) else $error("big endian lane wrong");
  narrow_low_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    active_ff && lw_ff == ext_bus_pkg::WIDTH_8 |-> lane_ff[3:1] == 3'h0) else $error("byte bank off lane 0");
  word_done_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    active_ff && ext_ready && k_ff == last_ff |=> rsp_valid) else $error("response not after last piece");
endmodule : ext_bus_adapter

// >>> src/ext_bus_pkg.sv
// constants for the external bus width and endian adapter
// assumes a 26-bit internal byte address with 10-bit bank pointers at its top
package ext_bus_pkg;
  // ************************************************************
  // address layout
  // ************************************************************
  localparam int ADDR_W = 26;
  localparam int PTR_W = 10;
  localparam int PTR_LSB = 16;
  localparam int EXT_ADDR_W = 22;
  localparam int IO_SUB_LSB = 14;
  localparam int IO_SUB_W = 2;
  localparam int BYTE_W = 8;
  localparam int LANES = 4;
  // ************************************************************
  // bank counts
  // ************************************************************
  localparam int ROM_BANKS = 6;
  localparam int IO_BANKS = 4;
  localparam int DRAM_BANKS = 4;
  // ************************************************************
  // width codes (log2 of bank width in bytes) and access sizes
  // ************************************************************
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  // ************************************************************
  // sequencer states
  // ************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ACCESS = 2'h1,
    ST_FINISH = 2'h3
  } seq_state_t;
endpackage : ext_bus_pkg

// >>> test/ext_mem_model.sv
// external memory model standing on the adapter's external pins
// assumes one piece at a time; narrow parts sit on the lowest data lanes
`timescale 1ns/1ps
module ext_mem_model (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic slow,
  input wire logic [21:0] ext_addr,
  input wire logic [31:0] data_o,
  input wire logic read_n,
  input wire logic [3:0] row_n,
  input wire logic [3:0] cas_n,
  input wire logic [3:0] io_sel_n,
  input wire logic [5:0] rom_sel_n,
  input wire logic [3:0] wbe_n,
  output logic ready,
  output logic [31:0] data_i
);
  // ************************************************************
  // storage and answer
  // ************************************************************
  logic [31:0] mem [256];
  logic [31:0] last_ff;
  logic [1:0] wait_ff;
  logic active;
  logic [3:0] lane_n;
  assign active = ~&{row_n, io_sel_n, rom_sel_n};
  assign ready = active && (!slow || wait_ff == 2'h2);
  assign lane_n = wbe_n & cas_n;
  // released data lines show a changing pattern, never the last value
  assign data_i = (active && !read_n) ? mem[ext_addr[7:0]] : ~last_ff;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wait_ff <= 2'h0;
      last_ff <= 32'h0;
    end else begin
      wait_ff <= (active && !ready) ? wait_ff + 2'h1 : 2'h0;
      last_ff <= data_i;
      if (ready && read_n) begin
        for (int i = 0; i < 4; i++) begin
          if (!lane_n[i]) begin
            mem[ext_addr[7:0]][8*i +: 8] <= data_o[8*i +: 8];
          end
        end
      end
    end
  end
endmodule : ext_mem_model

// >>> test/external_bus_width_endian_adapter_tb.sv
// self-checking testbench for the external bus width and endian adapter
// assumes ext_mem_model answers every piece on the external pins
`timescale 1ns/1ps
module external_bus_width_endian_adapter_tb;
  typedef struct {logic [21:0] a; logic [3:0] w; logic [3:0] c; logic [31:0] d; logic [5:0] r; logic [3:0] i;
    logic [3:0] row; logic e; logic n;} piece_t;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic little_endian = 1'b0;
  logic slow = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [1:0] req_size = 2'h0;
  logic [ext_bus_pkg::ADDR_W-1:0] req_addr = 26'h0;
  logic [31:0] req_wdata = 32'h0;
  logic [5:0][9:0] rom_base_ptr = {10'h0, 10'h0, 10'h0, 10'h2, 10'h1, 10'h0};
  logic [5:0][9:0] rom_next_ptr = {10'h0, 10'h0, 10'h0, 10'h3, 10'h2, 10'h1};
  logic [5:0][1:0] rom_width = {2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h0};
  logic [3:0][9:0] dram_base_ptr = {10'h0, 10'h0, 10'h0, 10'h3};
  logic [3:0][9:0] dram_next_ptr = {10'h0, 10'h0, 10'h0, 10'h4};
  logic [3:0][1:0] dram_width = {2'h0, 2'h0, 2'h0, 2'h2};
  logic [9:0] io_base_ptr = 10'h3F0;
  logic [3:0][1:0] io_width = {2'h0, 2'h0, 2'h2, 2'h0};
  logic req_ready, rsp_valid, rsp_error, oe, ext_ready, read_n;
  logic [31:0] rsp_rdata, data_o, data_i;
  logic [21:0] ext_addr;
  logic [3:0] row, cas, io_sel, wbe;
  logic [5:0] rom_sel;
  piece_t pcs[$];
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int lat;
  logic r_err;
  logic [31:0] r_data;
  ext_bus_adapter u_dut (.sys_clk(sys_clk), .nrst(nrst), .little_endian(little_endian), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_size(req_size), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_rdata(rsp_rdata),
    .rom_base_ptr(rom_base_ptr), .rom_next_ptr(rom_next_ptr), .rom_width(rom_width),
    .dram_base_ptr(dram_base_ptr), .dram_next_ptr(dram_next_ptr), .dram_width(dram_width),
    .io_base_ptr(io_base_ptr), .io_width(io_width), .ext_addr(ext_addr), .external_data_bus_o(data_o),
    .external_data_bus_i(data_i), .external_data_bus_oe(oe), .ext_ready(ext_ready), .read_strobe_n(read_n),
    .row_strobe_n(row), .column_strobe_n(cas), .io_bank_select_n(io_sel), .rom_bank_select_n(rom_sel),
    .byte_write_strobe_n(wbe));
  ext_mem_model u_mem (.sys_clk(sys_clk), .nrst(nrst), .slow(slow), .ext_addr(ext_addr), .data_o(data_o),
    .read_n(read_n), .row_n(row), .cas_n(cas), .io_sel_n(io_sel), .rom_sel_n(rom_sel), .wbe_n(wbe),
    .ready(ext_ready), .data_i(data_i));
  // ************************************************************
  // clock, piece monitor and hang limit
  // ************************************************************
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (nrst && ext_ready) begin
      pcs.push_back('{ext_addr, wbe, cas, data_o, rom_sel, io_sel, row, oe, read_n});
    end
    cycles++;
    if (cycles == 2000) begin
      errors++;
      complete_run();
    end
  end
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic complete_run();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic xfer(input logic wr, input logic [1:0] sz, input logic [25:0] ad, input logic [31:0] wd);
    logic bad;
    bad = 1'b0;
    #1;
    pcs.delete();
    req_write = wr;
    req_size = sz;
    req_addr = ad;
    req_wdata = wd;
    req_valid = 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (req_ready === 1'b1) break;
    end
    #1;
    req_valid = 1'b0;
    lat = 0;
    for (int n = 0; n < 100; n++) begin
      @(posedge sys_clk);
      lat++;
      bad = bad | (req_ready !== 1'b0);
      if (rsp_valid === 1'b1) break;
    end
    r_err = rsp_error;
    r_data = rsp_rdata;
    check("busy_ready", bad, 0);
  endtask : xfer
  task automatic pc(input int k, input logic [21:0] a, input logic [3:0] w, input logic [31:0] d,
    input logic [31:0] m);
    if (pcs.size() <= k) begin
      check("piece_count", pcs.size(), k + 1);
      return;
    end
    check("piece_addr", pcs[k].a, a);
    check("piece_strobe", pcs[k].w, w);
    check("piece_data", pcs[k].d & m, d & m);
    check("piece_oe", {pcs[k].n, pcs[k].e}, 2'h3);
  endtask : pc
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_word8();
    logic [31:0] w;
    w = 32'hA1B2C3D4;
    for (int le = 0; le < 2; le++) begin
      little_endian = le[0];
      slow = 1'b0;
      xfer(1'b1, 2'h2, 26'h0000040, w);
      check("w8_lat", lat, 5);
      check("w8_sel", pcs[0].r, 6'h3E);
      for (int k = 0; k < 4; k++) pc(k, 22'h40 + 22'(k), 4'hE, le ? w >> (8*k) : w >> (24 - 8*k), 32'hFF);
      slow = 1'b1;
      xfer(1'b0, 2'h2, 26'h0000040, 32'h0);
      check("w8_load", r_data, w);
      check("w8_load_pieces", pcs.size(), 4);
    end
    little_endian = 1'b0;
    slow = 1'b0;
  endtask : t_word8
  task automatic t_word16();
    xfer(1'b1, 2'h2, 26'h0010100, 32'h11223344);
    pc(0, 22'h80, 4'hC, 32'h1122, 32'hFFFF);
    pc(1, 22'h81, 4'hC, 32'h3344, 32'hFFFF);
    xfer(1'b0, 2'h2, 26'h0010100, 32'h0);
    check("w16_load", r_data, 32'h11223344);
  endtask : t_word16
  task automatic t_half();
    xfer(1'b1, 2'h1, 26'h0021230, 32'h5A6B5A6B);
    pc(0, 22'h48C, 4'h3, 32'h5A6B5A6B, 32'hFFFFFFFF);
    xfer(1'b1, 2'h1, 26'h0021232, 32'h7C8D7C8D);
    pc(0, 22'h48C, 4'hC, 32'h7C8D7C8D, 32'hFFFFFFFF);
    xfer(1'b0, 2'h2, 26'h0021230, 32'h0);
    check("h32_load", r_data, 32'h5A6B7C8D);
    check("load_wbe", pcs[0].w, 4'hF);
    check("load_rd_oe", {pcs[0].n, pcs[0].e}, 2'h0);
    xfer(1'b0, 2'h1, 26'h0021232, 32'h0);
    check("h32_half_load", r_data, 32'h7C8D7C8D);
    xfer(1'b0, 2'h0, 26'h0021231, 32'h0);
    check("b32_byte_load", r_data, 32'h6B6B6B6B);
    xfer(1'b1, 2'h1, 26'h0010104, 32'h3E4F3E4F);
    pc(0, 22'h82, 4'hC, 32'h3E4F, 32'hFFFF);
    check("h16_pieces", pcs.size(), 1);
    xfer(1'b1, 2'h1, 26'h0000048, 32'h3E4F3E4F);
    pc(0, 22'h48, 4'hE, 32'h3E, 32'hFF);
    pc(1, 22'h49, 4'hE, 32'h4F, 32'hFF);
    xfer(1'b1, 2'h1, 26'h001FFFE, 32'h6161);
    pc(0, 22'h7FFF, 4'hC, 32'h6161, 32'hFFFF);
    check("edge_sel", pcs[0].r, 6'h3D);
  endtask : t_half
  task automatic t_byte32();
    for (int le = 0; le < 2; le++) begin
      little_endian = le[0];
      xfer(1'b1, 2'h0, 26'h0021230, 32'h96969696);
      pc(0, 22'h48C, le ? 4'hE : 4'h7, 32'h96969696, le ? 32'hFF : 32'hFF000000);
    end
    little_endian = 1'b0;
  endtask : t_byte32
  task automatic t_banks();
    xfer(1'b1, 2'h2, 26'h0030010, 32'hCAFE0123);
    check("dram_strobes", {pcs[0].row, pcs[0].c, pcs[0].r}, 14'h383F);
    pc(0, 22'h4, 4'hF, 32'hCAFE0123, 32'hFFFFFFFF);
    xfer(1'b1, 2'h2, 26'h3F04020, 32'h0BADF00D);
    check("io_sel", {pcs[0].i, pcs[0].r}, 10'h37F);
    pc(0, 22'h8, 4'h0, 32'h0BADF00D, 32'hFFFFFFFF);
    check("io_err", r_err, 0);
    xfer(1'b0, 2'h2, 26'h1000000, 32'h0);
    check("miss_err", r_err, 1);
    check("miss_pieces", pcs.size(), 0);
    check("miss_lat", lat, 1);
  endtask : t_banks
  initial begin
    repeat (8) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    check("idle_strobes", {rom_sel, io_sel, row, cas, wbe}, 22'h3FFFFF);
    check("idle_bus", {req_ready, rsp_valid, oe, ext_addr}, {3'h4, 22'h0});
    @(posedge sys_clk);
    t_word8();
    t_word16();
    t_half();
    t_byte32();
    t_banks();
    complete_run();
  end
endmodule : external_bus_width_endian_adapter_tb
